/* File: design/lsc_pkg.sv */
package lsc_pkg;
   localparam int CLK_HZ = 250_000_000;
   // times in milliseconds
   localparam int HOLD_MS = 2000;
   localparam int BLINK_MS = 2000;
   localparam int PULSE_MS = 50;
   localparam int ACK_MS = 200;
   localparam int HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
   localparam int BLINK_CYC = (CLK_HZ / 1000) * BLINK_MS;
   localparam int PULSE_CYC = (CLK_HZ / 1000) * PULSE_MS;
   localparam int ACK_CYC = (CLK_HZ / 1000) * ACK_MS;

   // storage figures in bytes
   localparam int MEM_BYTES = 512 * 1024;
   localparam int CFG_BYTES = 10 * 1024;
   localparam int DATA_BYTES = MEM_BYTES - CFG_BYTES;
   localparam int ADDR_W = 20;
   localparam int LOW_PCT = 25;
   localparam logic [ADDR_W-1:0] LOW_FREE = ADDR_W'(DATA_BYTES * LOW_PCT / 100);
   localparam logic [ADDR_W-1:0] DATA_CAP = ADDR_W'(DATA_BYTES);
   localparam int NPAR = 8;
   localparam int BATT_W = 8;
   localparam int NCHEM = 3;

   // apb register byte addresses
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_START = 8'h04;
   localparam logic [7:0] A_WIDTH = 8'h08;
   localparam logic [7:0] A_BATT = 8'h0C;
   localparam logic [7:0] A_STAT = 8'h10;
   localparam logic [7:0] A_USED = 8'h14;
   localparam logic [7:0] A_IRQ = 8'h18;
   localparam logic [7:0] A_MASK = 8'h1C;
   localparam logic [7:0] A_THR0 = 8'h20;
   localparam int THR_N = 3;

   // ctrl fields
   localparam int C_LAUNCH = 0;
   localparam int C_MODE_LO = 1;
   localparam int C_WRAP = 3;
   localparam int C_CHEM_LO = 4;
   localparam int C_STOP = 6;

   // irq bits
   localparam int I_START = 0;
   localparam int I_LOWMEM = 1;
   localparam int I_LOWBAT = 2;
   localparam int I_SFAIL = 3;
   localparam int I_FULL = 4;
   localparam int NIRQ = 5;

   localparam logic [7:0] DEF_THR = 8'h40;

   typedef enum logic [1:0] {
      LSC_MODE_NOW,
      LSC_MODE_BUTTON,
      LSC_MODE_SCHED,
      LSC_MODE_ALIGNED
   } lsc_mode_t;
endpackage

/* File: design/lsc_top.sv */
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module lsc_top
   import lsc_pkg::*;
#(
   parameter int HOLD_N  = lsc_pkg::HOLD_CYC,
   parameter int BLINK_N = lsc_pkg::BLINK_CYC,
   parameter int PULSE_N = lsc_pkg::PULSE_CYC,
   parameter int ACK_N   = lsc_pkg::ACK_CYC
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        manual_launch_button,
   input  wire logic        start_time_reached,
   input  wire logic        sample_tick,
   input  wire logic        sensor_comm_fail,
   input  wire logic        cell_reversed,
   output logic             led_start_pending,
   output logic             led_sched_pending,
   output logic             led_logging,
   output logic             led_low_memory,
   output logic             led_low_battery,
   output logic             led_sensor_fail,
   output logic             irq
);
   import lsc_pkg::*;

   typedef enum logic [1:0] {LSC_IDLE, LSC_WAIT, LSC_LOG, LSC_DONE} lsc_state_t;

   lsc_state_t              state_reg;
   logic [31:0]             ctrl_reg;
   logic [ADDR_W-1:0]       used_reg;
   logic [1:0]              width_reg [NPAR];
   logic [BATT_W-1:0]       batt_reg;
   logic [BATT_W-1:0]       thr_reg [THR_N];
   logic [NIRQ-1:0]         irq_stat_reg;
   logic [NIRQ-1:0]         irq_mask_reg;
   logic                    sticky_fail_reg;
   logic [31:0]             blink_cnt_reg;
   logic [31:0]             hold_cnt_reg;
   logic [31:0]             ack_cnt_reg;
   logic                    btn_s1_reg;
   logic                    btn_s2_reg;
   logic                    tm_s1_reg;
   logic                    tm_s2_reg;
   logic                    sf_s1_reg;
   logic                    sf_s2_reg;
   logic                    rv_s1_reg;
   logic                    rv_s2_reg;
   logic                    hold_done_reg;

   logic                    wr;
   logic                    rd;
   logic                    launch;
   logic                    stop_req;
   lsc_mode_t               mode;
   logic                    wrap_en;
   logic [1:0]              chem;
   logic                    beat;
   logic                    pulse_on;
   logic                    acking;
   logic [ADDR_W-1:0]       bytes_per_int;
   logic [ADDR_W-1:0]       free_bytes;
   logic                    low_mem;
   logic                    low_bat;
   logic                    logging_active;
   logic                    mem_full;
   logic                    start_evt;
   logic [NIRQ-1:0]         evt;

   assign wr     = psel && penable && pwrite;
   assign rd     = psel && !penable && !pwrite;
   assign launch = wr && paddr == A_CTRL && pwdata[C_LAUNCH];
   assign stop_req = wr && paddr == A_CTRL && pwdata[C_STOP];
   assign mode   = lsc_mode_t'(ctrl_reg[C_MODE_LO +: 2]);
   assign wrap_en = ctrl_reg[C_WRAP];
   assign chem   = ctrl_reg[C_CHEM_LO +: 2];

   // two-flop synchronisers for the pin inputs except sample_tick
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         btn_s1_reg <= 1'b0;
         btn_s2_reg <= 1'b0;
         tm_s1_reg  <= 1'b0;
         tm_s2_reg  <= 1'b0;
         sf_s1_reg  <= 1'b0;
         sf_s2_reg  <= 1'b0;
         rv_s1_reg  <= 1'b0;
         rv_s2_reg  <= 1'b0;
      end
      else
      begin
         btn_s1_reg <= manual_launch_button;
         btn_s2_reg <= btn_s1_reg;
         tm_s1_reg  <= start_time_reached;
         tm_s2_reg  <= tm_s1_reg;
         sf_s1_reg  <= sensor_comm_fail;
         sf_s2_reg  <= sf_s1_reg;
         rv_s1_reg  <= cell_reversed;
         rv_s2_reg  <= rv_s1_reg;
      end
   end

   // one shared blink timebase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         blink_cnt_reg <= '0;
      else if (blink_cnt_reg >= 32'(BLINK_N - 1))
         blink_cnt_reg <= '0;
      else
         blink_cnt_reg <= blink_cnt_reg + 32'd1;
   end
   assign beat     = blink_cnt_reg == '0;
   assign pulse_on = blink_cnt_reg < 32'(PULSE_N);

   // button must be held without a break
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hold_cnt_reg  <= '0;
         hold_done_reg <= 1'b0;
      end
      else if (!btn_s2_reg || state_reg != LSC_WAIT)
      begin
         hold_cnt_reg  <= '0;
         hold_done_reg <= 1'b0;
      end
      else if (hold_cnt_reg < 32'(HOLD_N - 1))
         hold_cnt_reg <= hold_cnt_reg + 32'd1;
      else
         hold_done_reg <= 1'b1;
   end

   assign start_evt = state_reg == LSC_WAIT &&
                      ((mode == LSC_MODE_BUTTON && hold_done_reg) ||
                       ((mode == LSC_MODE_SCHED || mode == LSC_MODE_ALIGNED) && tm_s2_reg) ||
                       mode == LSC_MODE_NOW);

   // per-interval storage: widths code 0 unused, 1 eight bits, 2 sixteen bits
   always_comb
   begin
      bytes_per_int = '0;
      for (int i = 0; i < NPAR; i++)
         bytes_per_int = bytes_per_int + ADDR_W'(width_reg[i]);
   end
   assign mem_full   = used_reg + bytes_per_int > DATA_CAP;
   assign free_bytes = DATA_CAP - used_reg;
   // wrap never warns
   assign low_mem = !wrap_en && free_bytes < LOW_FREE;
   // an unused chemistry code never reads past the threshold table
   assign low_bat = (chem < 2'(THR_N) && batt_reg < thr_reg[chem]) || rv_s2_reg;

   // launch state machine; low battery has no say here
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_reg <= LSC_IDLE;
      else if (launch)
         state_reg <= LSC_WAIT;
      else if (stop_req)
         state_reg <= LSC_DONE;
      else
      begin
         case (state_reg)
            LSC_WAIT:
               if (start_evt)
                  state_reg <= LSC_LOG;
            LSC_LOG:
               if (sample_tick && !wrap_en && mem_full)
                  state_reg <= LSC_DONE;
            default:
               state_reg <= state_reg;
         endcase
      end
   end

   // sample byte count; wrap restarts at the base
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         used_reg <= '0;
      else if (launch)
         used_reg <= '0;
      else if (state_reg == LSC_LOG && sample_tick)
      begin
         if (!mem_full)
            used_reg <= used_reg + bytes_per_int;
         else if (wrap_en)
            used_reg <= bytes_per_int;
      end
   end

   // sticky failure, cleared only by relaunch
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sticky_fail_reg <= 1'b0;
      else if (sf_s2_reg)
         sticky_fail_reg <= 1'b1;
      else if (launch)
         sticky_fail_reg <= 1'b0;
   end

   // acknowledge flash after an accepted hold
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ack_cnt_reg <= '0;
      else if (start_evt && mode == LSC_MODE_BUTTON)
         ack_cnt_reg <= 32'(ACK_N);
      else if (ack_cnt_reg != '0)
         ack_cnt_reg <= ack_cnt_reg - 32'd1;
   end
   assign acking = ack_cnt_reg != '0;
   // a silent module masks the logging indicator
   assign logging_active = state_reg == LSC_LOG && !sf_s2_reg;

   // indicators, all registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         led_start_pending <= 1'b0;
         led_sched_pending <= 1'b0;
         led_logging       <= 1'b0;
         led_low_memory    <= 1'b0;
         led_low_battery   <= 1'b0;
         led_sensor_fail   <= 1'b0;
      end
      else if (acking)
      begin
         led_start_pending <= 1'b1;
         led_sched_pending <= 1'b1;
         led_logging       <= 1'b1;
         led_low_memory    <= 1'b1;
         led_low_battery   <= 1'b1;
         led_sensor_fail   <= 1'b1;
      end
      else
      begin
         led_start_pending <= pulse_on && state_reg == LSC_WAIT && mode == LSC_MODE_BUTTON;
         led_sched_pending <= pulse_on && state_reg == LSC_WAIT &&
                              (mode == LSC_MODE_SCHED || mode == LSC_MODE_ALIGNED);
         led_logging       <= pulse_on && logging_active;
         led_low_memory    <= pulse_on && low_mem && state_reg != LSC_IDLE;
         led_low_battery   <= pulse_on && low_bat;
         led_sensor_fail   <= pulse_on && (sticky_fail_reg || sf_s2_reg);
      end
   end

   // configuration registers; contents stand for retained launch setup
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg     <= '0;
         batt_reg     <= '1;
         irq_mask_reg <= '0;
         for (int i = 0; i < NPAR; i++)
            width_reg[i] <= 2'b00;
         for (int i = 0; i < THR_N; i++)
            thr_reg[i] <= DEF_THR;
      end
      else if (wr)
      begin
         if (paddr == A_CTRL)
            ctrl_reg <= {26'h0, pwdata[5:1], 1'b0};
         else if (paddr == A_WIDTH)
         begin
            for (int i = 0; i < NPAR; i++)
               width_reg[i] <= (pwdata[2*i +: 2] == 2'b11) ? 2'b10 : pwdata[2*i +: 2];
         end
         else if (paddr == A_BATT)
            batt_reg <= pwdata[BATT_W-1:0];
         else if (paddr == A_MASK)
            irq_mask_reg <= pwdata[NIRQ-1:0];
         else if (paddr >= A_THR0 && paddr < A_THR0 + 8'(4 * THR_N))
            thr_reg[2'((paddr - A_THR0) >> 2)] <= pwdata[BATT_W-1:0];
      end
   end

   // sticky interrupt status: set beats write-one-to-clear
   assign evt = {state_reg == LSC_LOG && sample_tick && mem_full && !wrap_en,
                 sf_s2_reg, low_bat, low_mem, start_evt};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_stat_reg <= '0;
      else if (wr && paddr == A_IRQ)
         irq_stat_reg <= (irq_stat_reg & ~pwdata[NIRQ-1:0]) | evt;
      else
         irq_stat_reg <= irq_stat_reg | evt;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(irq_stat_reg & irq_mask_reg);
   end

   // apb: read data captured in setup, zero-wait access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (rd)
         begin
            if (paddr == A_CTRL)
               prdata <= ctrl_reg;
            else if (paddr == A_WIDTH)
               prdata <= '0;
            else if (paddr == A_BATT)
               prdata <= 32'(batt_reg);
            else if (paddr == A_STAT)
               prdata <= 32'({sticky_fail_reg, low_bat, low_mem, state_reg});
            else if (paddr == A_USED)
               prdata <= 32'(used_reg);
            else if (paddr == A_IRQ)
               prdata <= 32'(irq_stat_reg);
            else if (paddr == A_MASK)
               prdata <= 32'(irq_mask_reg);
            else if (paddr >= A_THR0 && paddr < A_THR0 + 8'(4 * THR_N))
               prdata <= 32'(thr_reg[2'((paddr - A_THR0) >> 2)]);
            else
               prdata <= '0;
         end
      end
   end

   property p_no_log_before_hold;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == LSC_WAIT && mode == LSC_MODE_BUTTON && !hold_done_reg && !launch && !stop_req)
         |=> state_reg != LSC_LOG;
   endproperty
   a_no_log_before_hold: assert property (p_no_log_before_hold) else $error("logging began early");

   property p_sched_wait;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == LSC_WAIT && mode == LSC_MODE_SCHED && !tm_s2_reg && !launch) |=> state_reg != LSC_LOG;
   endproperty
   a_sched_wait: assert property (p_sched_wait) else $error("scheduled start too soon");

   property p_ack_flash;
      @(posedge pclk) disable iff (!presetn)
      (start_evt && mode == LSC_MODE_BUTTON && !launch) |=> ##1 (led_logging && led_low_battery && led_sensor_fail);
   endproperty
   a_ack_flash: assert property (p_ack_flash) else $error("no acknowledge flash");

   property p_log_pulse;
      @(posedge pclk) disable iff (!presetn)
      (logging_active && !acking && beat) |=> led_logging;
   endproperty
   a_log_pulse: assert property (p_log_pulse) else $error("logging pulse missed");

   property p_wrap_no_lowmem;
      @(posedge pclk) disable iff (!presetn)
      (wrap_en && !acking) |=> !led_low_memory;
   endproperty
   a_wrap_no_lowmem: assert property (p_wrap_no_lowmem) else $error("low memory with wrap");

   property p_lowbat_no_stop;
      @(posedge pclk) disable iff (!presetn)
      (state_reg == LSC_LOG && !mem_full && !launch && !stop_req) |=> state_reg == LSC_LOG;
   endproperty
   a_lowbat_no_stop: assert property (p_lowbat_no_stop) else $error("recording stopped");

   property p_sticky;
      @(posedge pclk) disable iff (!presetn)
      (sticky_fail_reg && !launch) |=> sticky_fail_reg;
   endproperty
   a_sticky: assert property (p_sticky) else $error("failure flag lost");

   property p_silent_only;
      @(posedge pclk) disable iff (!presetn)
      (sf_s2_reg && !acking) |=> !led_logging;
   endproperty
   a_silent_only: assert property (p_silent_only) else $error("logging lit during failure");

   property p_lowmem;
      @(posedge pclk) disable iff (!presetn)
      (low_mem && pulse_on && state_reg == LSC_LOG && !acking) |=> led_low_memory;
   endproperty
   a_lowmem: assert property (p_lowmem) else $error("low memory not shown");

   c_button_start: cover property (@(posedge pclk) state_reg == LSC_WAIT ##1 state_reg == LSC_LOG);
   c_full_stop: cover property (@(posedge pclk) state_reg == LSC_LOG ##1 state_reg == LSC_DONE);
   c_recovered: cover property (@(posedge pclk) led_sensor_fail && led_logging && !acking);
endmodule
`default_nettype wire

/* File: sim/lsc_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lsc_far_model
(
   input  wire logic pclk,
   input  wire logic led_start_pending,
   input  wire logic led_sched_pending,
   input  wire logic led_logging,
   output var logic  manual_launch_button,
   output var logic  start_time_reached,
   output var logic  sample_tick,
   output var logic  sensor_comm_fail,
   output var logic  cell_reversed
);
   // swaps are only legal after a pending blink; a logging blink withdraws the permission
   logic pending_seen;
   initial
   begin
      manual_launch_button = 1'b0;
      start_time_reached = 1'b0;
      sample_tick = 1'b0;
      sensor_comm_fail = 1'b0;
      cell_reversed = 1'b0;
      pending_seen = 1'b0;
   end
   always @(posedge pclk)
   begin
      if (led_logging && !led_start_pending)
         pending_seen <= 1'b0;
      else if (led_start_pending || led_sched_pending)
         pending_seen <= 1'b1;
   end
   task automatic press(input int n);
      @(posedge pclk);
      manual_launch_button <= 1'b1;
      repeat (n) @(posedge pclk);
      manual_launch_button <= 1'b0;
   endtask
   // back-to-back ticks, one logging interval per cycle, keep the memory fills short
   task automatic ticks(input int n);
      @(posedge pclk);
      sample_tick <= 1'b1;
      repeat (n) @(posedge pclk);
      sample_tick <= 1'b0;
   endtask
   task automatic set_pins(input logic f, input logic c, input logic s);
      @(posedge pclk);
      sensor_comm_fail <= f;
      cell_reversed <= c;
      start_time_reached <= s;
   endtask
   // the permission flag settles one edge after the indicator is seen
   task automatic swap_module(output bit ok);
      @(posedge pclk);
      ok = pending_seen;
   endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import lsc_pkg::*;
   localparam int BLINK = 16;
   localparam int PULSE = 4;
   logic        pclk = 1'b0;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        btn, start_t, tick, sfail, cellr;
   logic        l_sp, l_sc, l_lg, l_lm, l_lb, l_sf, irq;
   wire  [5:0]  leds = {l_sf, l_lb, l_lm, l_lg, l_sc, l_sp};
   int          error_cnt = 0;
   int          checks = 0;
   int          lg_cnt = 0;
   int          lm_cnt = 0;
   always #2 pclk = ~pclk;
   always @(posedge pclk)
   begin
      lg_cnt <= lg_cnt + int'(l_lg === 1'b1);
      lm_cnt <= lm_cnt + int'(l_lm === 1'b1);
   end
   lsc_top #(.HOLD_N(20), .BLINK_N(BLINK), .PULSE_N(PULSE), .ACK_N(6)) lsc_top_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .manual_launch_button(btn), .start_time_reached(start_t), .sample_tick(tick),
      .sensor_comm_fail(sfail), .cell_reversed(cellr), .led_start_pending(l_sp),
      .led_sched_pending(l_sc), .led_logging(l_lg), .led_low_memory(l_lm),
      .led_low_battery(l_lb), .led_sensor_fail(l_sf), .irq(irq));
   lsc_far_model lsc_far_model_i (
      .pclk(pclk), .led_start_pending(l_sp), .led_sched_pending(l_sc), .led_logging(l_lg),
      .manual_launch_button(btn), .start_time_reached(start_t), .sample_tick(tick),
      .sensor_comm_fail(sfail), .cell_reversed(cellr));
   task automatic complete_run;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one helper for both directions; waiting stops at the edge that samples pready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      q = prdata;
      chk("pslverr", 32'h0, {31'h0, pslverr});
      if (n >= 50)
         chk("pready", 32'h1, 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(nm, e, q & m);
   endtask
   task automatic wait_leds(input logic [5:0] m, input int lim, output bit seen);
      int n;
      n = 0;
      seen = 0;
      while (n < lim && !seen)
      begin
         @(posedge pclk);
         n++;
         seen = ((leds & m) === m);
      end
   endtask
   initial
   begin
      #340_000;
      error_cnt++;
      complete_run();
   end
   initial
   begin
      bit s;
      int n, b;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      chk("irq reset", 32'h0, {31'h0, irq});
      rd("stat reset", A_STAT, 32'h1F, 32'h0);
      rd("batt reset", A_BATT, 32'hFF, 32'hFF);
      for (int i = 0; i < THR_N; i++)
         rd("thr reset", A_THR0 + 8'(4 * i), 32'hFF, 32'h40);
      rd("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
      // button start: a short press must be ignored
      wr(A_CTRL, 32'h3);
      wait_leds(6'h01, 40, s);
      chk("start pending led", 32'h1, {31'h0, s});
      lsc_far_model_i.swap_module(s);
      chk("swap allowed", 32'h1, {31'h0, s});
      lsc_far_model_i.press(10);
      repeat (6) @(posedge pclk);
      rd("short press state", A_STAT, 32'h3, 32'h1);
      fork
         lsc_far_model_i.press(30);
         wait_leds(6'h3F, 60, s);
      join
      chk("ack all leds", 32'h1, {31'h0, s});
      rd("held press state", A_STAT, 32'h3, 32'h2);
      repeat (20) @(posedge pclk);
      wait_leds(6'h04, 40, s);
      // the pulse may have been caught part way, so time the next whole one
      n = 0;
      while (l_lg === 1'b1 && n < 100)
      begin
         @(posedge pclk);
         n++;
      end
      while (l_lg !== 1'b1 && n < 100)
      begin
         @(posedge pclk);
         n++;
      end
      n = 0;
      while (l_lg === 1'b1 && n < 100)
      begin
         @(posedge pclk);
         n++;
      end
      chk("logging pulse", PULSE, n);
      while (l_lg !== 1'b1 && n < 100)
      begin
         @(posedge pclk);
         n++;
      end
      chk("logging period", BLINK, n);
      lsc_far_model_i.swap_module(s);
      chk("swap refused", 32'h0, {31'h0, s});
      // interrupt: raise, mask, clear
      rd("irq start bit", A_IRQ, 32'h1, 32'h1);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(A_MASK, 32'h1);
      repeat (3) @(posedge pclk);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wr(A_IRQ, 32'h1);
      repeat (3) @(posedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wr(A_MASK, 32'h0);
      for (int m = 2; m < 4; m++)
      begin
         wr(A_CTRL, 32'(2 * m + 1));
         lsc_far_model_i.ticks(3);
         wait_leds(6'h02, 40, s);
         chk("sched led", 32'h1, {31'h0, s});
         rd("sched wait", A_STAT, 32'h3, 32'h1);
         rd("sched used", A_USED, 32'hFFFFF, 32'h0);
         lsc_far_model_i.set_pins(1'b0, 1'b0, 1'b1);
         repeat (6) @(posedge pclk);
         rd("sched start", A_STAT, 32'h3, 32'h2);
         lsc_far_model_i.set_pins(1'b0, 1'b0, 1'b0);
         repeat (4) @(posedge pclk);
      end
      // battery judged per chemistry; a low battery keeps logging
      wr(A_THR0 + 8'h4, 32'h20);
      wr(A_BATT, 32'h30);
      wr(A_WIDTH, 32'h9);
      wr(A_CTRL, 32'h11);
      repeat (4) @(posedge pclk);
      rd("lowbat chem1", A_STAT, 32'h8, 32'h0);
      wr(A_CTRL, 32'h01);
      repeat (4) @(posedge pclk);
      rd("lowbat chem0", A_STAT, 32'h8, 32'h8);
      wait_leds(6'h10, 40, s);
      chk("lowbat led", 32'h1, {31'h0, s});
      lsc_far_model_i.ticks(2);
      repeat (4) @(posedge pclk);
      rd("used mixed widths", A_USED, 32'hFFFFF, 32'h6);
      rd("still logging", A_STAT, 32'h3, 32'h2);
      wr(A_BATT, 32'hFF);
      lsc_far_model_i.set_pins(1'b0, 1'b1, 1'b0);
      repeat (6) @(posedge pclk);
      rd("reversed cell", A_STAT, 32'h8, 32'h8);
      lsc_far_model_i.set_pins(1'b0, 1'b0, 1'b0);
      repeat (6) @(posedge pclk);
      rd("cell ok", A_STAT, 32'h8, 32'h0);
      // module drop-out then recovery
      lsc_far_model_i.set_pins(1'b1, 1'b0, 1'b0);
      repeat (6) @(posedge pclk);
      b = lg_cnt;
      wait_leds(6'h20, 40, s);
      chk("fail led", 32'h1, {31'h0, s});
      repeat (40) @(posedge pclk);
      chk("logging led off", 32'h0, 32'(lg_cnt - b));
      lsc_far_model_i.set_pins(1'b0, 1'b0, 1'b0);
      repeat (6) @(posedge pclk);
      wait_leds(6'h24, 40, s);
      chk("fail with logging", 32'h1, {31'h0, s});
      rd("sticky fail", A_STAT, 32'h10, 32'h10);
      rd("irq fail bit", A_IRQ, 32'h8, 32'h8);
      // wrap on: the warning never lights
      wr(A_WIDTH, 32'hFFFF);
      wr(A_CTRL, 32'h09);
      b = lm_cnt;
      lsc_far_model_i.ticks(32200);
      repeat (4) @(posedge pclk);
      chk("wrap lowmem led", 32'h0, 32'(lm_cnt - b));
      rd("wrap lowmem", A_STAT, 32'h4, 32'h0);
      rd("wrap used", A_USED, 32'hFFFFF, 32'd1152);
      // wrap off: 16 bytes a tick, warning past 385536 used, stop at 514048
      wr(A_CTRL, 32'h01);
      lsc_far_model_i.ticks(24096);
      repeat (4) @(posedge pclk);
      rd("lowmem edge", A_STAT, 32'h4, 32'h0);
      rd("used edge", A_USED, 32'hFFFFF, 32'd385536);
      lsc_far_model_i.ticks(1);
      repeat (4) @(posedge pclk);
      rd("lowmem set", A_STAT, 32'h4, 32'h4);
      wait_leds(6'h08, 40, s);
      chk("lowmem led", 32'h1, {31'h0, s});
      lsc_far_model_i.ticks(8030);
      repeat (4) @(posedge pclk);
      rd("not yet full", A_STAT, 32'h3, 32'h2);
      // the first tick fills the final slot; the one after it finds no room and stops
      lsc_far_model_i.ticks(2);
      repeat (4) @(posedge pclk);
      rd("full stops", A_STAT, 32'h3, 32'h3);
      rd("used full", A_USED, 32'hFFFFF, 32'd514048);
      rd("irq full bit", A_IRQ, 32'h10, 32'h10);
      wr(A_CTRL, 32'h01);
      rd("relaunch", A_STAT, 32'h3, 32'h2);
      wr(A_CTRL, 32'h40);
      rd("stop request", A_STAT, 32'h3, 32'h3);
      complete_run();
   end
endmodule
`default_nettype wire
